// >>> hdl/dps_pkg.sv
package dps_pkg;

	typedef enum logic [1:0]
	{
		DPS_ST_ID   = 2'b00,
		DPS_ST_CMD  = 2'b01,
		DPS_ST_DATA = 2'b10,
		DPS_ST_IGN  = 2'b11
	} dps_frame_t;

	typedef enum logic [1:0]
	{
		DPS_PWR_MID    = 2'b00,
		DPS_PWR_WAIT   = 2'b01,
		DPS_PWR_RECALL = 2'b10,
		DPS_PWR_RUN    = 2'b11
	} dps_power_t;

endpackage : dps_pkg

// >>> hdl/dps_regs.svh
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH

// register addresses
`define DPS_ADDR_WIPER0      4'h0
`define DPS_ADDR_WIPER1      4'h1
`define DPS_ADDR_NV_LAST     4'h6
`define DPS_ADDR_RSVD        4'h7
`define DPS_ADDR_ACCESS      4'h8

// access control field positions
`define DPS_CTRL_VSEL_BIT    7
`define DPS_CTRL_PD_BIT      6
`define DPS_CTRL_BUSY_BIT    5

// reset values
`define DPS_WIPER_MID        7'h40
`define DPS_CTRL_VSEL_RST    1'b0
`define DPS_CTRL_PD_RST      1'b1
`define DPS_NV_DEFAULT       8'h40

// frame codes
// device code value is arbitrary
`define DPS_ID_BYTE          8'hA0
`define DPS_OP_READ          4'hB
`define DPS_OP_WRITE         4'hC

// timing
`define DPS_CLK_HZ           10000000
`define DPS_NV_WRITE_MS      20
`define DPS_RECALL_US        10

`endif

// >>> hdl/dps_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dps_sync
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// raw pins
	input  wire logic [3:0] async_i,
	// synchronised levels
	output logic      [3:0] sync_o
);

	logic [3:0] stage1;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stage1 <= 4'h9;
			sync_o <= 4'h9;
		end
		else
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule : dps_sync

`default_nettype wire

// >>> hdl/dps_tap_switch.sv
`include "dps_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// drives a one-hot tap select; on a move both taps close for one cycle
module dps_tap_switch
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [6:0]   pos_i,
	output logic      [127:0] tap_o
);

	logic [6:0] cur;
	logic       moving;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cur    <= `DPS_WIPER_MID;
			moving <= 1'b0;
			tap_o  <= 128'h1 << `DPS_WIPER_MID;
		end
		else if (pos_i != cur)
		begin
			tap_o  <= tap_o | (128'h1 << pos_i);
			moving <= 1'b1;
			cur    <= pos_i;
		end
		else
		begin
			tap_o  <= 128'h1 << cur;
			moving <= 1'b0;
		end
	end

endmodule : dps_tap_switch

`default_nettype wire

// >>> hdl/dps_top.sv
`include "dps_regs.svh"
// Function
// - wiper tap switches make the new connection before breaking the old one
// - at power return each stored power-up value is copied into its wiper
// - wiper position is 7 bits; 00h nearest low end, 7Fh nearest high end
// - tap select rises monotonically with the wiper value, 0 to 127
// - wipers start at 40h, then reload from stored values once reads are safe
// - address 0 selects wiper 0, address 1 selects wiper 1
// - addresses 2 to 6 are user bytes, 7 reserved, 8 access control
// - volatile select bit 7, default 0; 0 reaches stored plus wiper, 1 wiper only
// - power-down bit 6 resets to 1; 0 requests shutdown; ANDed with pin
// - normal only when pin high and bit 1, else shutdown
// - bit 5 is read-only write-busy flag, set during nonvolatile write
// - while busy, writes to stored, wiper and access control are ignored
// - SPI mode 0: sample on rising serial clock, shift out on falling
// - host drives clock and chip select low for whole transfer; device is slave
// - every byte travels most significant bit first
// - first byte must be the identification byte, checked before acting
// - second byte holds opcode in upper nibble, address in lower nibble
// - opcode 1011 reads, 1100 writes; nothing else is valid
// - write frame is id, instruction, data bytes, ended by chip select rising
// - pointer increments per data byte and wraps from 0110b to 0000b
// - nonvolatile write starts at chip select rise, lasting up to 20 ms
// - read frame is id, instruction, data; data shifted out on falling clock
// - serial output is released while chip select is high
// - reads continue while clocked, pointer incrementing and wrapping at 0110b
`timescale 1ns/1ps
`default_nettype none

module dps_top
#(
	parameter int unsigned NV_WRITE_CYCLES = `DPS_CLK_HZ / 1000 * `DPS_NV_WRITE_MS
)
(
	// clock and reset
	input  wire logic         CLK_SYS_I,
	input  wire logic         SYS_RST_I,
	// serial link pins
	input  wire logic         CS_N_I,
	input  wire logic         SCK_I,
	input  wire logic         SDI_I,
	output logic              SDO_O,
	output logic              SDO_OE_O,
	// shutdown pin
	input  wire logic         POWER_DOWN_N_I,
	// analog array controls
	output logic      [127:0] TAP0_O,
	output logic      [127:0] TAP1_O,
	output logic              SHUTDOWN_O,
	output logic              NV_WRITE_BUSY_O
);

	localparam int unsigned RECALL_CYCLES = `DPS_CLK_HZ / 1000000 * `DPS_RECALL_US;

	// synchronised pins
	logic [3:0] pins_s;
	logic       cs_n_s;
	logic       sck_s;
	logic       sdi_s;
	logic       pd_n_s;
	logic       sck_d;
	logic       cs_d;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;
	logic       cs_fall;

	// frame state
	dps_pkg::dps_frame_t frame;
	logic [2:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] rx_byte;
	logic       is_read;
	logic [3:0] ptr;
	logic [7:0] tx_byte;
	logic [7:0] rd_val;
	logic       armed;

	// storage
	logic [7:0] nv_mem [0:6];
	logic [6:0] wiper [0:1];
	logic       volatile_select;
	logic       pd_bit;
	logic       busy;
	logic [31:0] busy_cnt;
	logic       nv_pending;

	// power-up recall
	dps_pkg::dps_power_t pwr;
	logic [15:0] pwr_cnt;

	dps_sync u_sync
	(
		.clk_i   (CLK_SYS_I),
		.rst_i   (SYS_RST_I),
		.async_i ({CS_N_I, SCK_I, SDI_I, POWER_DOWN_N_I}),
		.sync_o  (pins_s)
	);

	assign cs_n_s = pins_s[3];
	assign sck_s  = pins_s[2];
	assign sdi_s  = pins_s[1];
	assign pd_n_s = pins_s[0];

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I)
		begin
			sck_d <= 1'b0;
			cs_d  <= 1'b1;
		end
		else
		begin
			sck_d <= sck_s;
			cs_d  <= cs_n_s;
		end
	end

	assign sck_rise = sck_s & ~sck_d & ~cs_n_s & armed;
	assign sck_fall = ~sck_s & sck_d & ~cs_n_s & armed;
	assign cs_rise  = cs_n_s & ~cs_d;
	assign cs_fall  = ~cs_n_s & cs_d;

	// next pointer with wrap after the last user byte
	function automatic logic [3:0] next_ptr(input logic [3:0] p);
		next_ptr = (p >= `DPS_ADDR_NV_LAST) ? `DPS_ADDR_WIPER0 : p + 4'h1;
	endfunction : next_ptr

	// register read decode
	function automatic logic [7:0] read_reg(input logic [3:0] a);
		if (a == `DPS_ADDR_ACCESS)
			read_reg = {volatile_select, pd_bit, busy, 5'h00};
		else if (a <= `DPS_ADDR_WIPER1 && volatile_select)
			read_reg = {1'b0, wiper[a[0]]};
		else if (a <= `DPS_ADDR_NV_LAST)
			read_reg = nv_mem[a[2:0]];
		else
			read_reg = 8'h00;
	endfunction : read_reg

	always_comb
	begin
		rd_val = read_reg(ptr);
	end

	// first chip select fall after reset arms the link
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I)
			armed <= 1'b0;
		else if (cs_fall)
			armed <= 1'b1;
	end

	// shift register and bit counter, msb first
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I || cs_n_s)
		begin
			bit_cnt  <= 3'h0;
			shift_in <= 8'h00;
		end
		else if (sck_rise)
		begin
			shift_in <= {shift_in[6:0], sdi_s};
			bit_cnt  <= bit_cnt + 3'h1;
		end
	end

	assign rx_byte = {shift_in[6:0], sdi_s};

	// frame sequencer
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I || cs_n_s)
		begin
			frame   <= dps_pkg::DPS_ST_ID;
			is_read <= 1'b0;
			ptr     <= 4'h0;
		end
		else if (sck_rise && bit_cnt == 3'h7)
		begin
			unique case (frame)
				dps_pkg::DPS_ST_ID:
					frame <= (rx_byte == `DPS_ID_BYTE) ? dps_pkg::DPS_ST_CMD
						: dps_pkg::DPS_ST_IGN;
				dps_pkg::DPS_ST_CMD:
				begin
					ptr <= rx_byte[3:0];
					if (rx_byte[7:4] == `DPS_OP_READ)
					begin
						is_read <= 1'b1;
						frame   <= dps_pkg::DPS_ST_DATA;
					end
					else if (rx_byte[7:4] == `DPS_OP_WRITE)
						frame <= dps_pkg::DPS_ST_DATA;
					else
						frame <= dps_pkg::DPS_ST_IGN;
				end
				dps_pkg::DPS_ST_DATA:
					ptr <= next_ptr(ptr);
				dps_pkg::DPS_ST_IGN:
					frame <= dps_pkg::DPS_ST_IGN;
			endcase
		end
	end

	// serial output on falling clock; open-drain, released when deselected
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I || cs_n_s)
		begin
			tx_byte  <= 8'hFF;
			SDO_O    <= 1'b0;
			SDO_OE_O <= 1'b0;
		end
		else if (sck_fall)
		begin
			if (frame == dps_pkg::DPS_ST_DATA && is_read && bit_cnt == 3'h0)
			begin
				tx_byte  <= {rd_val[6:0], 1'b1};
				SDO_OE_O <= ~rd_val[7];
			end
			else if (frame == dps_pkg::DPS_ST_DATA && is_read)
			begin
				tx_byte  <= {tx_byte[6:0], 1'b1};
				SDO_OE_O <= ~tx_byte[7];
			end
			else
				SDO_OE_O <= 1'b0;
		end
	end

	// register writes, recall and busy handling
	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I)
		begin
			volatile_select <= `DPS_CTRL_VSEL_RST;
			pd_bit     <= `DPS_CTRL_PD_RST;
			wiper[0]   <= `DPS_WIPER_MID;
			wiper[1]   <= `DPS_WIPER_MID;
			for (int i = 0; i < 7; i++)
				nv_mem[i] <= `DPS_NV_DEFAULT;
			nv_pending <= 1'b0;
			busy       <= 1'b0;
			busy_cnt   <= 32'h0;
			pwr        <= dps_pkg::DPS_PWR_MID;
			pwr_cnt    <= 16'h0;
		end
		else
		begin
			unique case (pwr)
				dps_pkg::DPS_PWR_MID:
					pwr <= dps_pkg::DPS_PWR_WAIT;
				dps_pkg::DPS_PWR_WAIT:
				begin
					pwr_cnt <= pwr_cnt + 16'h1;
					if (pwr_cnt == 16'(RECALL_CYCLES - 1))
						pwr <= dps_pkg::DPS_PWR_RECALL;
				end
				dps_pkg::DPS_PWR_RECALL:
				begin
					wiper[0] <= nv_mem[0][6:0];
					wiper[1] <= nv_mem[1][6:0];
					pwr      <= dps_pkg::DPS_PWR_RUN;
				end
				dps_pkg::DPS_PWR_RUN:
					pwr <= dps_pkg::DPS_PWR_RUN;
			endcase

			if (busy)
			begin
				if (busy_cnt == NV_WRITE_CYCLES - 1)
				begin
					busy     <= 1'b0;
					busy_cnt <= 32'h0;
				end
				else
					busy_cnt <= busy_cnt + 32'h1;
			end
			else if (cs_rise && nv_pending)
			begin
				busy       <= 1'b1;
				nv_pending <= 1'b0;
			end

			if (sck_rise && bit_cnt == 3'h7 && frame == dps_pkg::DPS_ST_DATA
				&& !is_read && !busy)
			begin
				if (ptr == `DPS_ADDR_ACCESS)
				begin
					volatile_select <= rx_byte[`DPS_CTRL_VSEL_BIT];
					pd_bit          <= rx_byte[`DPS_CTRL_PD_BIT];
				end
				else if (ptr <= `DPS_ADDR_WIPER1)
				begin
					wiper[ptr[0]] <= rx_byte[6:0];
					if (!volatile_select)
					begin
						nv_mem[ptr[2:0]] <= rx_byte;
						nv_pending       <= 1'b1;
					end
				end
				else if (ptr <= `DPS_ADDR_NV_LAST)
				begin
					nv_mem[ptr[2:0]] <= rx_byte;
					nv_pending       <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I)
		begin
			SHUTDOWN_O      <= 1'b0;
			NV_WRITE_BUSY_O <= 1'b0;
		end
		else
		begin
			SHUTDOWN_O      <= ~(pd_n_s & pd_bit);
			NV_WRITE_BUSY_O <= busy;
		end
	end

	// one-hot tap per wiper, tap index equals wiper value
	dps_tap_switch u_tap0
	(
		.clk_i (CLK_SYS_I),
		.rst_i (SYS_RST_I),
		.pos_i (wiper[0]),
		.tap_o (TAP0_O)
	);

	dps_tap_switch u_tap1
	(
		.clk_i (CLK_SYS_I),
		.rst_i (SYS_RST_I),
		.pos_i (wiper[1]),
		.tap_o (TAP1_O)
	);

endmodule : dps_top

`default_nettype wire

// >>> tb/dps_spi_host.sv
`timescale 1ns/1ps
`default_nettype none

module dps_spi_host
(
	// system clock and returned data
	input  wire logic clk_i,
	input  wire logic sdo_i,
	// link pins
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      sdi_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end

	// half of an 800 ns link period
	task half();
		repeat (4) @(negedge clk_i);
	endtask : half

	task arm();
		cs_n_o = 1'b0;
		half();
		cs_n_o = 1'b1;
		repeat (5) half();
	endtask : arm

	// sends nb bytes from the top of tx, read bits land in rx
	task xfer(input logic [47:0] tx, input int nb, output logic [47:0] rx);
		int i;
		cs_n_o = 1'b0;
		half();
		for (i = 0; i < nb * 8; i++)
		begin
			sdi_o = tx[47 - i];
			half();
			sck_o = 1'b1;
			half();
			rx = {rx[46:0], sdo_i};
			sck_o = 1'b0;
		end
		half();
		sdi_o = ~sdi_o;
		cs_n_o = 1'b1;
		repeat (5) half();
	endtask : xfer
endmodule : dps_spi_host

`default_nettype wire

// >>> tb/dps_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module dps_top_props
#(
	parameter int unsigned NV_WRITE_CYCLES = 50
)
(
	// watched ports
	input wire logic         CLK_SYS_I,
	input wire logic         SYS_RST_I,
	input wire logic         CS_N_I,
	input wire logic         POWER_DOWN_N_I,
	input wire logic         SDO_O,
	input wire logic         SDO_OE_O,
	input wire logic [127:0] TAP0_O,
	input wire logic [127:0] TAP1_O,
	input wire logic         SHUTDOWN_O,
	input wire logic         NV_WRITE_BUSY_O
);
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (SYS_RST_I);

	int unsigned busy_cnt;

	always_ff @(posedge CLK_SYS_I)
	begin
		if (SYS_RST_I || !NV_WRITE_BUSY_O)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end

	a_sdo_release: assert property (CS_N_I [*5] |-> !SDO_OE_O)
		else $error("output driven while deselected");
	a_sdo_drain: assert property (SDO_OE_O |-> !SDO_O)
		else $error("output drives a high level");
	a_pin_shutdown: assert property (!POWER_DOWN_N_I [*5] |-> SHUTDOWN_O)
		else $error("pin low without shutdown");
	a_busy_cs_high: assert property ($rose(NV_WRITE_BUSY_O) |-> CS_N_I)
		else $error("busy began inside a frame");
	a_busy_length: assert property ($fell(NV_WRITE_BUSY_O) |->
		busy_cnt inside {[NV_WRITE_CYCLES - 1:NV_WRITE_CYCLES + 1]})
		else $error("busy span wrong");
	a_tap_count: assert property ($countones(TAP0_O) inside {[1:2]})
		else $error("tap closure count wrong");
	a_tap0_make: assert property (($changed(TAP0_O) && $onehot(TAP0_O))
		|-> $countones($past(TAP0_O)) == 2)
		else $error("pot 0 broke before make");
	a_tap1_make: assert property (($changed(TAP1_O) && $onehot(TAP1_O))
		|-> $countones($past(TAP1_O)) == 2)
		else $error("pot 1 broke before make");
endmodule : dps_top_props

`default_nettype wire

// >>> tb/test_dps_top.sv
`include "dps_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_dps_top;
	localparam int NV = 1000;
	localparam logic [19:0] ROWS [7] = '{20'h8DFC0, 20'h01212, 20'h17F7F,
		20'h75500, 20'h84040, 20'h03333, 20'h5A5A5};

	logic         clk;
	logic         rst;
	logic         cs_n;
	logic         sck;
	logic         sdi;
	logic         sdo;
	logic         sdo_oe;
	logic         pd_n;
	logic [127:0] tap0;
	logic [127:0] tap1;
	logic         shut;
	logic         busy;
	logic         line;
	logic [47:0]  rx;
	int           error_cnt;
	int           checks;
	int           r;

	// open drain with pull-up
	assign line = sdo_oe ? sdo : 1'b1;

	dps_top #(.NV_WRITE_CYCLES(NV)) dut (.CLK_SYS_I(clk), .SYS_RST_I(rst),
		.CS_N_I(cs_n), .SCK_I(sck), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
		.POWER_DOWN_N_I(pd_n), .TAP0_O(tap0), .TAP1_O(tap1), .SHUTDOWN_O(shut),
		.NV_WRITE_BUSY_O(busy));

	dps_spi_host host (.clk_i(clk), .sdo_i(line), .cs_n_o(cs_n), .sck_o(sck),
		.sdi_o(sdi));

	initial clk = 1'b0;
	always #50 clk = ~clk;

	task check(input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask : check

	task finish_test();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task wr(input logic [3:0] a, input logic [7:0] d);
		host.xfer({`DPS_ID_BYTE, `DPS_OP_WRITE, a, d, 24'h0}, 3, rx);
	endtask : wr

	task rd(input logic [3:0] a, input int n);
		host.xfer({`DPS_ID_BYTE, `DPS_OP_READ, a, 32'h0}, 2 + n, rx);
	endtask : rd

	task idle();
		int k;
		for (k = 0; k < 2 * NV && busy !== 1'b0; k++)
			@(negedge clk);
	endtask : idle

	initial
	begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	initial
	begin
		rst = 1'b1;
		pd_n = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		check({sdo_oe, busy, shut}, 3'b000);
		check(tap0, 128'h1 << 64);
		repeat (1100) @(negedge clk);
		host.arm();
		for (r = 0; r < 7; r++)
		begin
			wr(ROWS[r][19:16], ROWS[r][15:8]);
			idle();
			rd(ROWS[r][19:16], 1);
			check(rx[7:0], ROWS[r][7:0]);
		end
		check(tap0, 128'h1 << 8'h33);
		check(tap1, 128'h1 << 127);
		wr(4'h3, 8'h11);
		check(busy, 1'b1);
		rd(4'h8, 1);
		check(rx[7:0], 8'h60);
		wr(4'h8, 8'h80);
		idle();
		rd(4'h8, 1);
		check(rx[7:0], 8'h40);
		pd_n = 1'b0;
		repeat (6) @(negedge clk);
		check(shut, 1'b1);
		pd_n = 1'b1;
		wr(4'h8, 8'h80);
		check(shut, 1'b1);
		wr(4'h8, 8'hC0);
		check(shut, 1'b0);
		host.xfer({8'hA1, 8'hC0, 8'h05, 24'h0}, 3, rx);
		check(tap0, 128'h1 << 8'h33);
		host.xfer({`DPS_ID_BYTE, 8'hD8, 32'h0}, 3, rx);
		check(rx[7:0], 8'hFF);
		rd(4'h5, 3);
		check(rx[23:0], 24'hA54033);
		host.xfer({`DPS_ID_BYTE, `DPS_OP_WRITE, 4'h0, 16'h2122, 16'h0}, 4, rx);
		check(tap0, 128'h1 << 8'h21);
		check(tap1, 128'h1 << 8'h22);
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		check(tap0, 128'h1 << 64);
		check(tap1, 128'h1 << 64);
		repeat (200) @(negedge clk);
		host.arm();
		rd(4'h8, 1);
		check(rx[7:0], 8'h40);
		finish_test();
	end
endmodule : test_dps_top

bind dps_top dps_top_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) props
	(.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .CS_N_I(CS_N_I),
	.POWER_DOWN_N_I(POWER_DOWN_N_I), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O),
	.TAP0_O(TAP0_O), .TAP1_O(TAP1_O), .SHUTDOWN_O(SHUTDOWN_O),
	.NV_WRITE_BUSY_O(NV_WRITE_BUSY_O));

`default_nettype wire
